//--- core/iisg_pkg.sv
package iisg_pkg;
	// i/o address width on the isa side
	localparam int ADDR_W = 10;
	// command block decode window
	localparam logic [9:0] CMD_LO = 10'h1F0;
	localparam logic [9:0] CMD_HI = 10'h1F7;
	// control block decode window
	localparam logic [9:0] CTL_LO = 10'h3F6;
	localparam logic [9:0] CTL_HI = 10'h3F7;
	// port shared with the floppy controller
	localparam logic [9:0] SHARED_PORT = 10'h3F7;
	// bit position of the shared data bit
	localparam int BIT7 = 7;
	// access phase states, one-hot
	typedef enum logic [2:0] {
		IISG_IDLE = 3'h1,
		IISG_READ = 3'h2,
		IISG_WRITE = 3'h4
	} iisg_state_type;
endpackage

//--- core/iisg_dec_if.sv
`timescale 1ns/1ps
// decode results passed from the decoder to the top
interface iisg_dec_if;
	logic hit_cmd;
	logic hit_ctl;
	logic hit_shared;
	modport dec (output hit_cmd, output hit_ctl, output hit_shared);
	modport use_side (input hit_cmd, input hit_ctl, input hit_shared);
endinterface

//--- core/iisg_decode.sv
`timescale 1ns/1ps
// address decoder for the two drive register windows
module iisg_decode
	import iisg_pkg::*;
(
	input wire logic [9:0] sa,
	input wire logic aen,
	iisg_dec_if.dec dec
);
	// R12: master address picks the window
	// dma cycles (aen high) never select the drive
	assign dec.hit_cmd = !aen && sa >= CMD_LO && sa <= CMD_HI;
	assign dec.hit_ctl = !aen && sa >= CTL_LO && sa <= CTL_HI;
	assign dec.hit_shared = !aen && sa == SHARED_PORT;
endmodule // iisg_decode

//--- core/iisg_glue.sv
`timescale 1ns/1ps
// Operation
// R01: select command block on 1F0h-1F7h
// R02: select control block on 3F6h-3F7h
// R03: upper enable only on 16-bit access
// R04: lower enable on every drive access
// R05: port 3F7 read: floppy bit onto data7
// R06: other drive ports: drive bit7 line passes
// R07: 3F7 read shares bits with floppy
// R08: direction high only during drive reads
// R09: 16-bit request pulled up, default 8-bit
// R10: device pulls 16-bit request for wide transfers
// R11: reset output inverted externally for drive
// R12: master drives low address bits
// R13: drive interrupts on request line fourteen
// R14: ordinary isa i/o read/write strobes
// R15: power cut output under software control
// R16: disabled interface keeps outputs inactive; drive_power_cut still follows power_cut_req
module iisg_glue
	import iisg_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [9:0] sa,
	input wire logic aen,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic iocs16_n,
	input wire logic hd_enable,
	input wire logic power_cut_req,
	input wire logic fdc_disk_change,
	input wire logic sd7_in,
	output logic sd7_out,
	output logic sd7_oe,
	input wire logic drive_bit7_in,
	output logic drive_bit7_out,
	output logic drive_bit7_oe,
	output logic drive_sel_cmd_block,
	output logic drive_sel_ctrl_block,
	output logic buf_en_upper,
	output logic buf_en_lower,
	output logic xcvr_direction,
	output logic drive_power_cut
);
	// decoder results
	iisg_dec_if dec_bus();
	// access phase
	iisg_state_type state;
	iisg_state_type next_state;
	// captured wide request of the current access
	logic wide;
	// combined hit of any drive window
	logic hit;
	// strobes active
	logic rd;
	logic wr;

	iisg_decode u_dec (
		.sa(sa),
		.aen(aen),
		.dec(dec_bus.dec)
	);

	assign hit = hd_enable && (dec_bus.hit_cmd || dec_bus.hit_ctl);
	// R14: plain isa io strobes
	assign rd = !ior_n;
	assign wr = !iow_n;

	// phase tracking: follows the io strobes of a drive access
	always_comb begin
		case (state)
			IISG_IDLE: begin
				if (hit && rd) begin
					next_state = IISG_READ;
				end else if (hit && wr) begin
					next_state = IISG_WRITE;
				end else begin
					next_state = IISG_IDLE;
				end
			end
			IISG_READ: next_state = (rd && hit) ? IISG_READ : IISG_IDLE;
			IISG_WRITE: next_state = (wr && hit) ? IISG_WRITE : IISG_IDLE;
			default: next_state = IISG_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= IISG_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// R09: wide request sampled live; pulled-up input reads high = 8-bit
	always_ff @(posedge clk) begin
		if (srst) begin
			wide <= 1'b0;
		end else begin
			wide <= hit && !iocs16_n;
		end
	end

	// R01: command block chip select, active low
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_sel_cmd_block <= 1'b1;
		end else begin
			// R16: disable forces inactive
			drive_sel_cmd_block <= !(hd_enable && dec_bus.hit_cmd);
		end
	end

	// R02: control block chip select, active low
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_sel_ctrl_block <= 1'b1;
		end else begin
			drive_sel_ctrl_block <= !(hd_enable && dec_bus.hit_ctl);
		end
	end

	// R04: lower buffer enable on any strobed drive access
	always_ff @(posedge clk) begin
		if (srst) begin
			buf_en_lower <= 1'b1;
		end else begin
			buf_en_lower <= !(hit && (rd || wr));
		end
	end

	// R03: upper buffer enable only when wide was requested
	always_ff @(posedge clk) begin
		if (srst) begin
			buf_en_upper <= 1'b1;
		end else begin
			buf_en_upper <= !(hit && (rd || wr) && !iocs16_n);
		end
	end

	// R08: direction high only while a drive read is running
	always_ff @(posedge clk) begin
		if (srst) begin
			xcvr_direction <= 1'b0;
		end else begin
			xcvr_direction <= hit && rd;
		end
	end

	// R15: power cut follows the power management request
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_power_cut <= 1'b0;
		end else begin
			drive_power_cut <= power_cut_req;
		end
	end

	// R05: shared port read returns floppy disk change on data bit 7
	// R06: other drive ports route the drive bit 7 line both ways
	always_ff @(posedge clk) begin
		if (srst) begin
			sd7_out <= 1'b0;
			sd7_oe <= 1'b0;
			drive_bit7_out <= 1'b0;
			drive_bit7_oe <= 1'b0;
		end else if (hit && rd && dec_bus.hit_shared) begin
			// R07: floppy owns bit 7, drive bit 7 not passed
			sd7_out <= fdc_disk_change;
			sd7_oe <= 1'b1;
			drive_bit7_out <= 1'b0;
			drive_bit7_oe <= 1'b0;
		end else if (hit && rd) begin
			sd7_out <= drive_bit7_in;
			sd7_oe <= 1'b1;
			drive_bit7_out <= 1'b0;
			drive_bit7_oe <= 1'b0;
		end else if (hit && wr && !dec_bus.hit_shared) begin
			sd7_out <= 1'b0;
			sd7_oe <= 1'b0;
			drive_bit7_out <= sd7_in;
			drive_bit7_oe <= 1'b1;
		end else begin
			sd7_out <= 1'b0;
			sd7_oe <= 1'b0;
			drive_bit7_out <= 1'b0;
			drive_bit7_oe <= 1'b0;
		end
	end

	// R01: command select follows decode one cycle later
	a_cmd_select: assert property ( // R01
		@(posedge clk) disable iff (srst)
		(hd_enable && !aen && sa >= CMD_LO && sa <= CMD_HI)
		|=> !drive_sel_cmd_block)
		else $error("command select missing");
	// R02: control select follows decode
	a_ctl_select: assert property ( // R02
		@(posedge clk) disable iff (srst)
		(hd_enable && !aen && sa >= CTL_LO && sa <= CTL_HI)
		|=> !drive_sel_ctrl_block)
		else $error("control select missing");
	// R03: upper never alone
	a_upper_lower: assert property ( // R03
		@(posedge clk) disable iff (srst)
		!buf_en_upper |-> !buf_en_lower)
		else $error("upper enable without lower");
	// R03: narrow access keeps upper off
	a_upper_narrow: assert property ( // R03
		@(posedge clk) disable iff (srst)
		$past(iocs16_n) |-> buf_en_upper)
		else $error("upper enable on narrow access");
	// R09: upper only together with captured wide request
	a_upper_wide: assert property ( // R09
		@(posedge clk) disable iff (srst)
		!buf_en_upper |-> wide)
		else $error("upper enable without wide request");
	// R04: lower enable on reads
	a_lower_access: assert property ( // R04
		@(posedge clk) disable iff (srst)
		(hit && rd) |=> !buf_en_lower)
		else $error("lower enable missing");
	// R05: shared port returns floppy bit
	a_shared_bit: assert property ( // R05
		@(posedge clk) disable iff (srst)
		(hit && rd && dec_bus.hit_shared)
		|=> sd7_oe && sd7_out == $past(fdc_disk_change))
		else $error("shared bit not from floppy");
	// R06: other ports pass drive bit
	a_drive_bit: assert property ( // R06
		@(posedge clk) disable iff (srst)
		(hit && rd && !dec_bus.hit_shared)
		|=> sd7_out == $past(drive_bit7_in) && !drive_bit7_oe)
		else $error("drive bit not passed");
	// R08: direction only after read
	a_dir_read: assert property ( // R08
		@(posedge clk) disable iff (srst)
		xcvr_direction |-> $past(hit && rd))
		else $error("direction high outside read");
	// R16: disabled outputs stay inactive
	a_disabled: assert property ( // R16
		@(posedge clk) disable iff (srst)
		!$past(hd_enable) |-> drive_sel_cmd_block && drive_sel_ctrl_block
		&& buf_en_upper && buf_en_lower && !xcvr_direction)
		else $error("outputs active while disabled");
	// R15: power cut follows request
	a_power_cut: assert property ( // R15
		@(posedge clk) disable iff (srst)
		power_cut_req |=> drive_power_cut)
		else $error("power cut not following");

	c_read_wide: cover property (@(posedge clk)
		!buf_en_upper && xcvr_direction);
	c_write_narrow: cover property (@(posedge clk)
		state == IISG_WRITE && buf_en_upper);
	c_shared_read: cover property (@(posedge clk)
		sd7_oe && $past(dec_bus.hit_shared));
endmodule // iisg_glue

//--- verification/iisg_drive_model.sv
`timescale 1ns/1ps
// behavioural drive: answers bit 7 while selected for a read
module iisg_drive_model (
	input wire logic clk,
	input wire logic drive_reset_n,
	input wire logic drive_sel_cmd_block,
	input wire logic drive_sel_ctrl_block,
	input wire logic xcvr_direction,
	output logic drive_bit7_in,
	output logic irq14
);
	// data bit the drive would return, toggles every cycle outside reset
	logic data = 1'b0;
	// last level seen on the line, inverted once released
	logic last = 1'b0;
	logic drv;
	assign drv = (!drive_sel_cmd_block || !drive_sel_ctrl_block) &&
		xcvr_direction;
	assign drive_bit7_in = drv ? data : ~last;
	// track line and toggle data
	always @(posedge clk) begin
		last <= drive_bit7_in;
		// reset input of the drive is active low
		if (!drive_reset_n) begin
			data <= 1'b0;
			irq14 <= 1'b0;
		end else begin
			data <= ~data;
			// interrupt request after any selected cycle with direction low, strobe or not
			irq14 <= (!drive_sel_cmd_block || !drive_sel_ctrl_block) &&
				!xcvr_direction;
		end
	end
endmodule // iisg_drive_model

//--- verification/isa_ide_select_glue_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); \
	fails++; end end
module isa_ide_select_glue_bench;
	import iisg_pkg::*;
	logic clk = 0, srst = 1, aen = 0, ior_n = 1, iow_n = 1, iocs16_n = 1;
	logic hd_enable = 1, pcr = 0, fdc = 0, sd7_in = 0;
	logic [9:0] sa = 10'h000;
	wire logic s_out, s_oe, b_in, b_out, b_oe, cmd, ctl, up, lo, dir, pc;
	int fails = 0, comparisons = 0, seed = 75402, cyc = 0;
	// addresses around both decode windows
	logic [9:0] tab [8] = '{10'h1EF, 10'h1F0, 10'h1F7, 10'h1F8,
		10'h3F5, 10'h3F6, 10'h3F7, 10'h3F8};
	// expected outputs for the next negative edge
	logic e_cmd, e_ctl, e_up, e_lo, e_dir, e_pc, e_so, e_sd, e_bo, e_bd;
	// predictions wait here until the compare; pred is the one in use
	logic [9:0] exp_q [$];
	logic [9:0] pred;
	iisg_glue u_iisg_glue (.clk(clk), .srst(srst), .sa(sa), .aen(aen),
		.ior_n(ior_n), .iow_n(iow_n), .iocs16_n(iocs16_n),
		.hd_enable(hd_enable), .power_cut_req(pcr),
		.fdc_disk_change(fdc), .sd7_in(sd7_in), .sd7_out(s_out),
		.sd7_oe(s_oe), .drive_bit7_in(b_in), .drive_bit7_out(b_out),
		.drive_bit7_oe(b_oe), .drive_sel_cmd_block(cmd),
		.drive_sel_ctrl_block(ctl), .buf_en_upper(up),
		.buf_en_lower(lo), .xcvr_direction(dir), .drive_power_cut(pc));
	// the drive sees the inverted reset
	iisg_drive_model u_iisg_drive_model (.clk(clk), .drive_reset_n(!srst),
		.drive_sel_cmd_block(cmd), .drive_sel_ctrl_block(ctl),
		.xcvr_direction(dir), .drive_bit7_in(b_in), .irq14());
	initial begin
		forever #20 clk = ~clk;
	end
	// model from inputs before the edge, then new random stimulus
	always @(posedge clk) begin
		logic ok, cm, ct, hd, st;
		logic [31:0] r;
		ok = !aen && hd_enable;
		cm = ok && sa >= CMD_LO && sa <= CMD_HI;
		ct = ok && sa >= CTL_LO && sa <= CTL_HI;
		hd = cm || ct;
		st = !ior_n || !iow_n;
		e_cmd = srst || !cm;
		e_ctl = srst || !ct;
		e_lo = srst || !(hd && st);
		e_up = srst || !(hd && st && !iocs16_n);
		e_dir = !srst && hd && !ior_n;
		e_pc = !srst && pcr;
		e_so = e_dir;
		e_sd = (sa == SHARED_PORT) ? fdc : b_in;
		e_bo = !srst && hd && !iow_n && sa != SHARED_PORT;
		e_bd = sd7_in;
		exp_q.push_back({e_cmd, e_ctl, e_up, e_lo, e_dir, e_pc, e_so,
			e_sd, e_bo, e_bd});
		cyc++;
		r = $random(seed);
		// start reset plus a short second one in mid-run
		srst <= cyc < 10 || (cyc >= 1500 && cyc < 1504);
		sa <= r[3] ? tab[r[2:0]] : r[13:4];
		aen <= r[16:14] == 0;
		hd_enable <= r[19:17] != 0;
		ior_n <= r[21:20] != 0;
		iow_n <= r[21:20] != 1;
		iocs16_n <= r[22];
		pcr <= r[23];
		fdc <= r[24];
		sd7_in <= r[25];
	end
	// compare once the edge's updates have landed
	always @(negedge clk) begin
		// oldest prediction belongs to the edge just passed
		if (exp_q.size() > 0) begin
			pred = exp_q.pop_front();
		end
		if (cyc > 1) begin
			`CHK("cmd_sel", pred[9], cmd)
			`CHK("ctl_sel", pred[8], ctl)
			`CHK("en_upper", pred[7], up)
			`CHK("en_lower", pred[6], lo)
			`CHK("direction", pred[5], dir)
			`CHK("power_cut", pred[4], pc)
			`CHK("sd7_oe", pred[3], s_oe)
			`CHK("bit7_oe", pred[1], b_oe)
			if (pred[3]) `CHK("sd7_out", pred[2], s_out)
			if (pred[1]) `CHK("bit7_out", pred[0], b_out)
		end
	end
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		results();
	end
	// watchdog well beyond the planned run
	initial begin
		repeat (6000) @(posedge clk);
		fails++;
		results();
	end
endmodule // isa_ide_select_glue_bench
